// File: hw/flow_through_burst_sram.sv
/*
 * flow-through burst static memory, 128K words of 18 bits, on a shared
 * two-way data bus with chip selects, byte lane writes, advance/load
 * bursting and a clock qualify input.
 * assumes the controller runs on CLK; the output enable is an
 * asynchronous gate and the burst order strap is a quiet level.
 */
`include "fts_cfg.svh"

module flow_through_burst_sram (
   // clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // control from the controller
   input wire logic CLOCK_QUALIFY_N,
   input wire logic CHIP_SEL_FIRST_N,
   input wire logic CHIP_SEL_SECOND,
   input wire logic CHIP_SEL_THIRD_N,
   input wire logic [`ADDR_W-1:0] ADDR,
   input wire logic WRITE_N,
   input wire logic [`LANE_CNT-1:0] BYTE_LANE_SEL_N,
   input wire logic ADVANCE_OR_LOAD,
   input wire logic OUTPUT_EN_N,
   // burst order strap
   input wire logic BURST_ORDER,
   // data bus, three signals per pin
   input wire logic [`LANE_CNT*`BYTE_W-1:0] DATA_IN,
   output logic [`LANE_CNT*`BYTE_W-1:0] DATA_OUT,
   output logic [`LANE_CNT*`BYTE_W-1:0] DATA_OE,
   // lane parity bus, three signals per pin
   input wire logic [`LANE_CNT-1:0] LANE_PARITY_BITS_IN,
   output logic [`LANE_CNT-1:0] LANE_PARITY_BITS_OUT,
   output logic [`LANE_CNT-1:0] LANE_PARITY_BITS_OE
);

   // ****************************************************************
   // helpers
   // ****************************************************************
   // lane k of a word is {parity k, byte k}, so parity follows its lane
   function automatic fts_pkg::word_t merge_lanes(
      input fts_pkg::word_t old_w,
      input fts_pkg::word_t new_w,
      input fts_pkg::lanes_t sel_n
   );
      fts_pkg::word_t res;
      res = old_w;
      for (int k = 0; k < `LANE_CNT; k++) begin
         if (!sel_n[k]) begin
            res[k*`LANE_W +: `LANE_W] = new_w[k*`LANE_W +: `LANE_W];
         end
      end
      return res;
   endfunction

   function automatic logic [`BEAT_W-1:0] burst_low(
      input logic [`BEAT_W-1:0] start,
      input logic [`BEAT_W-1:0] beat,
      input logic order
   );
      logic [`BEAT_W-1:0] res;
      if (order == `ORDER_LINEAR) begin
         res = start + beat;
      end else begin
         res = start ^ beat;
      end
      return res;
   endfunction

   // ****************************************************************
   // declarations
   // ****************************************************************
   fts_pkg::access_t access_q;
   logic [`ADDR_W-1:`BEAT_W] upper_q;
   logic [`BEAT_W-1:0] start_q;
   logic [`BEAT_W-1:0] beat_q;
   fts_pkg::lanes_t lane_sel_n_q;
   logic order_meta_q;
   logic order_q;
   fts_pkg::word_t mem_q [`MEM_WORDS];

   logic en;
   logic selected;
   fts_pkg::addr_t cur_addr;
   fts_pkg::word_t bus_word;
   fts_pkg::word_t read_word;
   logic drive;

   logic wq_in_valid;
   logic wq_in_ready;
   logic [`ENT_W-1:0] wq_in_data;
   logic wq_out_valid;
   logic wq_out_ready;
   logic [`ENT_W-1:0] wq_out_data;
   logic [`WQ_DEPTH*`ENT_W-1:0] wq_view_data;
   logic [`WQ_DEPTH-1:0] wq_view_valid;
   logic [`ENT_W-1:0] ent;

   // ****************************************************************
   // edge qualification
   // ****************************************************************
   // a full write queue suspends like the qualify input; it cannot fill
   // in normal traffic since every write cycle also drains one entry
   assign en = !CLOCK_QUALIFY_N && wq_in_ready;
   assign selected = !CHIP_SEL_FIRST_N && CHIP_SEL_SECOND && !CHIP_SEL_THIRD_N;

   // ****************************************************************
   // burst order strap
   // ****************************************************************
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         order_meta_q <= `STRAP_RST;
         order_q <= `STRAP_RST;
      end else begin
         order_meta_q <= BURST_ORDER;
         order_q <= order_meta_q;
      end
   end

   // ****************************************************************
   // access state
   // ****************************************************************
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         access_q <= fts_pkg::ST_IDLE;
      end else if (en && !ADVANCE_OR_LOAD) begin
         if (!selected) begin
            access_q <= fts_pkg::ST_IDLE;
         end else if (!WRITE_N) begin
            access_q <= fts_pkg::ST_WRITE;
         end else begin
            access_q <= fts_pkg::ST_READ;
         end
      end
   end

   // ****************************************************************
   // address and burst counter
   // ****************************************************************
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         upper_q <= '0;
         start_q <= `BEAT_RST;
         beat_q <= `BEAT_RST;
      end else if (en) begin
         if (!ADVANCE_OR_LOAD) begin
            if (selected) begin
               upper_q <= ADDR[`ADDR_W-1:`BEAT_W];
               start_q <= ADDR[`BEAT_W-1:0];
               beat_q <= `BEAT_RST;
            end
         end else if (access_q != fts_pkg::ST_IDLE) begin
            beat_q <= beat_q + 1'b1;
         end
      end
   end

   // lane selects travel with the address of their beat
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         lane_sel_n_q <= `NO_LANES;
      end else if (en) begin
         lane_sel_n_q <= BYTE_LANE_SEL_N;
      end
   end

   assign cur_addr = {upper_q, burst_low(start_q, beat_q, order_q)};

   // ****************************************************************
   // write path
   // ****************************************************************
   assign bus_word = {LANE_PARITY_BITS_IN[1], DATA_IN[15:8],
                      LANE_PARITY_BITS_IN[0], DATA_IN[7:0]};
   // write data is taken at the edge that closes the data phase
   assign wq_in_valid = !CLOCK_QUALIFY_N && access_q == fts_pkg::ST_WRITE
                        && lane_sel_n_q != `NO_LANES;
   assign wq_in_data = {cur_addr, lane_sel_n_q, bus_word};
   // reads own the array port, writes retire in the other cycles
   assign wq_out_ready = access_q != fts_pkg::ST_READ;

   write_queue #(
      .WIDTH(`ENT_W),
      .DEPTH(`WQ_DEPTH)
   ) u_wq (
      .clk(CLK),
      .reset(RESET),
      .in_valid(wq_in_valid),
      .in_ready(wq_in_ready),
      .in_data(wq_in_data),
      .out_valid(wq_out_valid),
      .out_ready(wq_out_ready),
      .out_data(wq_out_data),
      .view_data(wq_view_data),
      .view_valid(wq_view_valid)
   );

   // self-timed retirement into the array
   always_ff @(posedge CLK) begin
      if (wq_out_valid && wq_out_ready) begin
         mem_q[wq_out_data[`ENT_ADDR_LSB +: `ADDR_W]] <= merge_lanes(
            mem_q[wq_out_data[`ENT_ADDR_LSB +: `ADDR_W]],
            wq_out_data[`ENT_DATA_LSB +: `WORD_W],
            wq_out_data[`ENT_LANE_LSB +: `LANE_CNT]);
      end
   end

   // ****************************************************************
   // read path
   // ****************************************************************
   // queued writes overlay the array oldest first, so a read right
   // after a write to the same word sees the new data
   always_comb begin
      ent = '0;
      read_word = mem_q[cur_addr];
      for (int i = 0; i < `WQ_DEPTH; i++) begin
         ent = wq_view_data[i*`ENT_W +: `ENT_W];
         if (wq_view_valid[i] && ent[`ENT_ADDR_LSB +: `ADDR_W] == cur_addr) begin
            read_word = merge_lanes(read_word, ent[`ENT_DATA_LSB +: `WORD_W],
                                    ent[`ENT_LANE_LSB +: `LANE_CNT]);
         end
      end
   end

   // ****************************************************************
   // output drivers
   // ****************************************************************
   // idle covers deselect and the load cycle leaving it; write phases
   // never drive, whatever the output enable
   assign drive = access_q == fts_pkg::ST_READ && !OUTPUT_EN_N;
   assign DATA_OUT = {read_word[16:9], read_word[7:0]};
   assign LANE_PARITY_BITS_OUT = {read_word[17], read_word[8]};
   assign DATA_OE = {(`LANE_CNT*`BYTE_W){drive}};
   assign LANE_PARITY_BITS_OE = {`LANE_CNT{drive}};

endmodule

// File: hw/fts_cfg.svh
/*
 * constants of the flow-through burst memory: sizes, field positions
 * of the write queue entry and reset values.
 * assumes it is included by its bare name from the package and the
 * design modules.
 */
`ifndef FTS_CFG_SVH
`define FTS_CFG_SVH

// ****************************************************************
// sizes
// ****************************************************************
`define ADDR_W 17
`define MEM_WORDS 131072
`define WORD_W 18
`define BYTE_W 8
`define LANE_W 9
`define LANE_CNT 2
`define BEAT_W 2
`define WQ_DEPTH 16

// ****************************************************************
// write queue entry: {address, lane selects, word}
// ****************************************************************
`define ENT_DATA_LSB 0
`define ENT_LANE_LSB 18
`define ENT_ADDR_LSB 20
`define ENT_W 37

// ****************************************************************
// encodings and reset values
// ****************************************************************
`define ORDER_LINEAR 1'b0
`define STRAP_RST 1'b1
`define BEAT_RST 2'h0
`define NO_LANES 2'h3

`endif

// File: hw/fts_pkg.sv
/*
 * types shared by the burst memory modules.
 * assumes the constants header is on the include path.
 */
`include "fts_cfg.svh"

package fts_pkg;

   // ****************************************************************
   // access state, gray along idle -> read -> write
   // ****************************************************************
   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_READ  = 2'h1,
      ST_WRITE = 2'h3
   } access_t;

   typedef logic [`ADDR_W-1:0] addr_t;
   typedef logic [`WORD_W-1:0] word_t;
   typedef logic [`LANE_CNT-1:0] lanes_t;

endpackage

// File: hw/write_queue.sv
/*
 * first-in first-out queue of flip-flops with valid/ready on both
 * sides and an age-ordered view of every stored entry.
 * assumes one clock, a power-of-two depth and an active-high
 * asynchronous reset.
 */
`include "fts_cfg.svh"

module write_queue #(
   parameter int WIDTH = `ENT_W,
   parameter int DEPTH = `WQ_DEPTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // contents, oldest first
   output logic [DEPTH*WIDTH-1:0] view_data,
   output logic [DEPTH-1:0] view_valid
);

   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [PW:0] cnt_q;
   logic push;
   logic pop;

   // ****************************************************************
   // handshake
   // ****************************************************************
   assign in_ready = cnt_q != (PW+1)'(DEPTH);
   assign out_valid = cnt_q != '0;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_q[rd_q];

   // ****************************************************************
   // storage and pointers
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // pointers wrap by overflow, hence the power-of-two depth
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   // ****************************************************************
   // age-ordered view
   // ****************************************************************
   for (genvar g = 0; g < DEPTH; g++) begin : g_view
      assign view_data[g*WIDTH +: WIDTH] = mem_q[rd_q + PW'(g)];
      assign view_valid[g] = (PW+1)'(g) < cnt_q;
   end

endmodule

// File: verification/ctl_model.sv
/*
 * controller model: drives the memory's control pins and its side of
 * the shared data bus, one beat per call.
 * assumes the bench calls issue just after each falling clock edge.
 */
`include "fts_cfg.svh"

module ctl_model (
   // control pins
   output logic qual_n,
   output logic [2:0] sel,
   output logic adv,
   output logic wr_n,
   output logic [`ADDR_W-1:0] addr,
   output logic [`LANE_CNT-1:0] lanes_n,
   // shared bus, device side
   input wire logic [15:0] dq_out,
   input wire logic [15:0] dq_oe,
   input wire logic [1:0] par_out,
   input wire logic [1:0] par_oe,
   // shared bus, resolved level
   output logic [15:0] dq_in,
   output logic [1:0] par_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [17:0] drv = 18'h0;
   logic phase = 1'b0;
   logic next_ph = 1'b0;
   logic [17:0] next_w = 18'h0;

   // no pull on the bus: a released line toggles so stale data never passes
   assign dq_in = (dq_oe & dq_out) | (~dq_oe & {drv[16:9], drv[7:0]});
   assign par_in = (par_oe & par_out) | (~par_oe & {drv[17], drv[8]});

   initial begin
      qual_n = 1'b0;
      sel = 3'b011;
      adv = 1'b0;
      wr_n = 1'b1;
      addr = '0;
      lanes_n = 2'h3;
   end

   task automatic issue(input logic q, input logic [2:0] s, input logic a, input logic w,
                        input logic [`ADDR_W-1:0] ad, input logic [1:0] l,
                        input logic [17:0] wd, input logic wbeat);
      // qual_n still holds the level of the edge just passed
      if (!qual_n) begin
         phase = next_ph;
         drv = next_ph ? next_w : ~drv;
      end else if (!phase) begin
         drv = ~drv;
      end
      qual_n = q;
      sel = s;
      adv = a;
      wr_n = w;
      addr = ad;
      lanes_n = l;
      next_ph = wbeat;
      next_w = wd;
   endtask
endmodule

// File: verification/fts_properties.sv
/*
 * checker of the burst memory's port behaviour, bound to the top module.
 * assumes one clock domain and the constants header on the include path.
 */
`include "fts_cfg.svh"

module fts_properties (
   // clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // control
   input wire logic CLOCK_QUALIFY_N,
   input wire logic CHIP_SEL_FIRST_N,
   input wire logic CHIP_SEL_SECOND,
   input wire logic CHIP_SEL_THIRD_N,
   input wire logic WRITE_N,
   input wire logic ADVANCE_OR_LOAD,
   input wire logic OUTPUT_EN_N,
   // data bus
   input wire logic [`LANE_CNT*`BYTE_W-1:0] DATA_OUT,
   input wire logic [`LANE_CNT*`BYTE_W-1:0] DATA_OE,
   input wire logic [`LANE_CNT-1:0] LANE_PARITY_BITS_OE
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   wire logic selected = !CHIP_SEL_FIRST_N && CHIP_SEL_SECOND && !CHIP_SEL_THIRD_N;

   // ********
   // access steps
   // ********
   sequence s_load; !CLOCK_QUALIFY_N && !ADVANCE_OR_LOAD; endsequence
   sequence s_rd_load; s_load ##0 (selected && WRITE_N); endsequence
   sequence s_wr_load; s_load ##0 (selected && !WRITE_N); endsequence
   sequence s_desel; s_load ##0 !selected; endsequence

   // ********
   // properties
   // ********
   property p_write_off; s_wr_load |=> DATA_OE == '0; endproperty
   a_write_off: assert property (p_write_off) else $error("driving in write phase");
   property p_desel_off; s_desel |=> DATA_OE == '0 && LANE_PARITY_BITS_OE == '0; endproperty
   a_desel_off: assert property (p_desel_off) else $error("driving when deselected");
   property p_oe_gate; OUTPUT_EN_N |-> DATA_OE == '0; endproperty
   a_oe_gate: assert property (p_oe_gate) else $error("driving with gate high");
   property p_read_on; s_rd_load ##1 !OUTPUT_EN_N |-> &DATA_OE; endproperty
   a_read_on: assert property (p_read_on) else $error("read phase not driven");
   property p_adv_read;
      s_rd_load ##1 (!CLOCK_QUALIFY_N && ADVANCE_OR_LOAD) ##1 !OUTPUT_EN_N |-> &DATA_OE;
   endproperty
   a_adv_read: assert property (p_adv_read) else $error("burst read stopped");
   property p_hold;
      (CLOCK_QUALIFY_N && !OUTPUT_EN_N && DATA_OE[0]) ##1 !OUTPUT_EN_N
         |-> $stable(DATA_OUT) && DATA_OE[0];
   endproperty
   a_hold: assert property (p_hold) else $error("read word moved while held");
   property p_wr_ignored;
      s_rd_load ##1 (CLOCK_QUALIFY_N && !WRITE_N) ##1 !OUTPUT_EN_N |-> &DATA_OE;
   endproperty
   a_wr_ignored: assert property (p_wr_ignored) else $error("held edge took write");
   property p_lanes_same;
      (DATA_OE == '0 || DATA_OE == '1) && LANE_PARITY_BITS_OE == {2{DATA_OE[0]}};
   endproperty
   a_lanes_same: assert property (p_lanes_same) else $error("bus enables differ");
   property p_b2b;
      s_rd_load ##1 (s_wr_load ##0 !OUTPUT_EN_N) |-> &DATA_OE ##1 DATA_OE == '0;
   endproperty
   a_b2b: assert property (p_b2b) else $error("read then write turn wrong");
   property p_reset_off; disable iff (1'b0) RESET |-> DATA_OE == '0; endproperty
   a_reset_off: assert property (p_reset_off) else $error("driving in reset");
endmodule

bind flow_through_burst_sram fts_properties u_props (.CLK, .RESET, .CLOCK_QUALIFY_N,
   .CHIP_SEL_FIRST_N, .CHIP_SEL_SECOND, .CHIP_SEL_THIRD_N, .WRITE_N, .ADVANCE_OR_LOAD,
   .OUTPUT_EN_N, .DATA_OUT, .DATA_OE, .LANE_PARITY_BITS_OE);

// File: verification/tb_top.sv
/*
 * self-checking bench of the burst memory: word-map reference model,
 * random mixed traffic in both burst orders.
 * assumes the design, the controller model and the checker compile first.
 */
`include "fts_cfg.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int base_addr = 'h0abc8;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic oe_n = 1'b0;
   logic order = 1'b0;
   logic q_n, adv, wr_n;
   logic [2:0] sel;
   logic [`ADDR_W-1:0] addr;
   logic [1:0] lanes_n, par_in, par_out, par_oe;
   logic [15:0] dq_in, dq_out, dq_oe;
   logic [17:0] mem [int];
   logic [17:0] pw;
   logic [1:0] pl;
   int acc = 0, start = 0, bt = 0, cur = 0, pa = 0, pend = 0;
   int failures = 0;
   int n_tests = 0;

   always #2 clk = ~clk;

   flow_through_burst_sram u_dut (.CLK(clk), .RESET(reset), .CLOCK_QUALIFY_N(q_n),
      .CHIP_SEL_FIRST_N(sel[0]), .CHIP_SEL_SECOND(sel[1]), .CHIP_SEL_THIRD_N(sel[2]),
      .ADDR(addr), .WRITE_N(wr_n), .BYTE_LANE_SEL_N(lanes_n), .ADVANCE_OR_LOAD(adv),
      .OUTPUT_EN_N(oe_n), .BURST_ORDER(order), .DATA_IN(dq_in), .DATA_OUT(dq_out),
      .DATA_OE(dq_oe), .LANE_PARITY_BITS_IN(par_in), .LANE_PARITY_BITS_OUT(par_out),
      .LANE_PARITY_BITS_OE(par_oe));
   ctl_model u_ctl (.qual_n(q_n), .sel(sel), .adv(adv), .wr_n(wr_n), .addr(addr),
      .lanes_n(lanes_n), .dq_out(dq_out), .dq_oe(dq_oe), .par_out(par_out),
      .par_oe(par_oe), .dq_in(dq_in), .par_in(par_in));

   // ********
   // checking and one beat of traffic
   // ********
   task automatic check(input logic [17:0] g, input logic [17:0] e);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("mismatch at %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic op(input logic q, input logic [2:0] s, input logic a, input logic w,
                     input int off, input logic [1:0] l, input logic oe);
      logic [17:0] wd;
      wd = 18'($urandom);
      @(negedge clk);
      if (acc == 1 && !oe_n) begin
         check({par_oe, dq_oe}, 18'h3ffff);
         check({par_out[1], dq_out[15:8], par_out[0], dq_out[7:0]}, mem[cur]);
      end else begin
         check({par_oe, dq_oe}, 18'h0);
      end
      if (acc == 0) a = 1'b0;
      if (!q) begin
         // the pending write lands at this edge, before any new read of it
         if (pend != 0) mem[pa] = {pl[1] ? mem[pa][17:9] : pw[17:9],
                                   pl[0] ? mem[pa][8:0] : pw[8:0]};
         pend = 0;
         if (!a) begin
            acc = (s == 3'b010) ? (w ? 1 : 2) : 0;
            start = off;
            bt = 0;
         end else if (acc != 0) begin
            bt = (bt + 1) % 4;
         end
         cur = (start & 4) | ((order ? start ^ bt : start + bt) & 3);
         if (acc == 2) begin
            pend = 1;
            pa = cur;
            pl = l;
            pw = wd;
         end
      end
      oe_n = oe;
      u_ctl.issue(q, s, a, w, 17'(base_addr + off), l, wd, acc == 2);
   endtask

   task automatic wrap_up();
      $display("counts: %0d compares, %0d mismatches", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ********
   // main sequence
   // ********
   initial begin
      void'($urandom(79203));
      repeat (4) @(negedge clk);
      check({par_oe, dq_oe}, 18'h0);
      reset = 1'b0;
      for (int i = 0; i < 8; i++) op(1'b0, 3'b010, 1'b0, 1'b0, i, 2'h0, 1'b0);
      $display("test fill done");
      for (int o = 0; o < 2; o++) begin
         order = o[0];
         repeat (3) op(1'b0, 3'b011, 1'b0, 1'b1, 0, 2'h3, 1'b0);
         repeat (200) begin
            op($urandom % 4 == 0, ($urandom % 4 == 0) ? 3'($urandom) : 3'b010,
               1'($urandom), 1'($urandom), $urandom % 8, 2'($urandom),
               $urandom % 8 == 0);
         end
         $display("test random order %0d done", o);
      end
      op(1'b0, 3'b011, 1'b0, 1'b1, 0, 2'h3, 1'b0);
      wrap_up();
   end
endmodule
